// ### hdl/bscan_tap.sv
// Overview of operation
// - Sample TMS on test clock rise
// - Shift on rise, TDO changes on fall
// - Capture TDI on test clock rise
// - TDO driven only while shifting
// - Four-bit controller stepped by TMS only
// - 3-bit instruction, 000 is external test
// - 001 samples pins without disturbing them
// - 101 floats every user pin
// - 110 clamps pins, bypass selected
// - 111 places bypass between TDI, TDO
// - Power-on reset enters Test-Logic-Reset
// - Five TMS-high rises reach Test-Logic-Reset
// - No separate test reset input
// - Undriven TMS reads as one
// - Bypass, identification, boundary registers; bypass default
// - 32-bit identification register loaded, but no instruction selects it
// - Three boundary cells per pin
// - Boundary cells form one TDI-TDO chain
// - Cells sit between core and pin buffers
//
// Top of the boundary-scan test logic. The test clock, TMS and TDI come from
// pins and are sampled on clk, which must run well above the test clock
// (100 MHz against at most 20 MHz). reset_n is the power-on reset only.
`timescale 1ns/1ps
`include "bscan_tap_regs.svh"

module bscan_tap
  import bscan_pkg::*;
#(
  parameter int NUM_IO = 4,
  parameter logic [31:0] ID_CODE = 32'h0000_0001 // Arbitrary value
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsDriven,
  input wire logic tdi,
  output logic tdoOut,
  output logic tdoOe,
  input wire logic [NUM_IO-1:0] coreOut,
  input wire logic [NUM_IO-1:0] coreOe,
  input wire logic [NUM_IO-1:0] padIn,
  output logic [NUM_IO-1:0] padOut,
  output logic [NUM_IO-1:0] padOe,
  output logic [NUM_IO-1:0] coreIn,
  output logic [`BSCAN_IR_WIDTH-1:0] irValue,
  output bscan_pkg::bscan_state_t tapState
);
  import bscan_pkg::*;

  localparam int CHAIN_LEN = NUM_IO * `BSCAN_CELLS_PER_IO;

  // Elaboration check on the pin count; an empty chain cannot be scanned
  if (NUM_IO < 1)
  begin : gNumIoCheck
    $error("NUM_IO must be at least one");
  end

  logic [2:0] tckSync_reg;
  logic tmsMeta_reg;
  logic tmsSync_reg;
  logic tdiMeta_reg;
  logic tdiSync_reg;
  logic tckRise;
  logic tckFall;
  logic tmsEff;
  bscan_state_t state;
  logic [`BSCAN_IR_WIDTH-1:0] irShift_reg;
  logic [`BSCAN_IR_WIDTH-1:0] ir_reg;
  logic bypass_reg;
  logic [`BSCAN_ID_WIDTH-1:0] idShift_reg;
  logic [CHAIN_LEN-1:0] bsShift_reg;
  logic [CHAIN_LEN-1:0] bsUpdate_reg;
  logic [CHAIN_LEN-1:0] bsCapture;
  bscan_dr_sel_t drSel;
  logic serialBit;
  logic [NUM_IO-1:0] padOutNext;
  logic [NUM_IO-1:0] padOeNext;
  logic [NUM_IO-1:0] coreInNext;

  // Two-flop synchronisers; edge detect reads only the second stage onward
  // The pull-up is folded in ahead of the first flop so the drive flag is synchronised too
  // TMS pull-up
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tckSync_reg <= 3'h0;
      tmsMeta_reg <= 1'h1;
      tmsSync_reg <= 1'h1;
      tdiMeta_reg <= 1'h1;
      tdiSync_reg <= 1'h1;
    end
    else
    begin
      tckSync_reg <= {tckSync_reg[1:0], tck};
      tmsMeta_reg <= tms | ~tmsDriven;
      tmsSync_reg <= tmsMeta_reg;
      tdiMeta_reg <= tdi;
      tdiSync_reg <= tdiMeta_reg;
    end
  end

  assign tckRise = tckSync_reg[1] & ~tckSync_reg[2];
  assign tckFall = ~tckSync_reg[1] & tckSync_reg[2];

  // Synchronised TMS with the pull-up already applied
  assign tmsEff = tmsSync_reg;

  // Controller; five ones from any state reach reset with no extra reset pin
  // TMS-high reset
  bscan_tap_fsm uFsm (
    .clk(clk),
    .reset_n(reset_n),
    .tckRise(tckRise),
    .tmsSync(tmsEff),
    .state(state)
  );

  // Instruction shift and update; bypass is forced for as long as the controller
  // sits in Test-Logic-Reset, so five TMS ones restore it without a further rise
  // reset instruction
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irShift_reg <= `BSCAN_IR_BYPASS;
      ir_reg <= `BSCAN_IR_BYPASS;
    end
    else if (state == TEST_LOGIC_RESET)
      ir_reg <= `BSCAN_IR_BYPASS;
    else if (tckRise)
    begin
      unique case (state)
        CAPTURE_IR: irShift_reg <= `BSCAN_IR_CAPTURE;
        SHIFT_IR: irShift_reg <= {tdiSync_reg, irShift_reg[`BSCAN_IR_WIDTH-1:1]};
        UPDATE_IR: ir_reg <= irShift_reg;
        default: ;
      endcase
    end
  end

  // Register selection; unknown codes and clamp fall back to bypass
  // bypass default
  always_comb
  begin
    unique case (ir_reg)
      `BSCAN_IR_EXTEST: drSel = SEL_BOUNDARY;
      `BSCAN_IR_SAMPLE: drSel = SEL_BOUNDARY;
      default: drSel = SEL_BYPASS;
    endcase
  end

  // Pin-side capture values: three cells per pin, in, out, enable
  // three cells
  always_comb
  begin
    bsCapture = '0;
    for (int i = 0; i < NUM_IO; i++)
    begin
      bsCapture[3*i] = padIn[i];
      bsCapture[3*i+1] = coreOut[i];
      bsCapture[3*i+2] = coreOe[i];
    end
  end

  // Bypass stage
  // bypass captures zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bypass_reg <= 1'h0;
    else if (tckRise && state == CAPTURE_DR)
      bypass_reg <= 1'h0;
    else if (tckRise && state == SHIFT_DR && drSel == SEL_BYPASS)
      bypass_reg <= tdiSync_reg;
  end

  // Identification register, loaded at capture, least bit out first
  // identification shift
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      idShift_reg <= '0;
    else if (tckRise && state == CAPTURE_DR)
      idShift_reg <= ID_CODE;
    else if (tckRise && state == SHIFT_DR && drSel == SEL_IDCODE)
      idShift_reg <= {tdiSync_reg, idShift_reg[`BSCAN_ID_WIDTH-1:1]};
  end

  // Boundary chain: TDI enters the top, bit 0 leaves at TDO
  // single chain
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bsShift_reg <= '0;
    else if (tckRise && state == CAPTURE_DR && drSel == SEL_BOUNDARY)
      bsShift_reg <= bsCapture;
    else if (tckRise && state == SHIFT_DR && drSel == SEL_BOUNDARY)
      bsShift_reg <= {tdiSync_reg, bsShift_reg[CHAIN_LEN-1:1]};
  end

  // Update latches hold the pattern driven in external test and clamp
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      bsUpdate_reg <= '0;
    else if (tckFall && state == UPDATE_DR && drSel == SEL_BOUNDARY)
      bsUpdate_reg <= bsShift_reg;
  end

  // Serial bit of the register now in the path
  always_comb
  begin
    serialBit = bypass_reg;
    if (state == SHIFT_IR)
      serialBit = irShift_reg[0];
    else
    begin
      unique case (drSel)
        SEL_IDCODE: serialBit = idShift_reg[0];
        SEL_BOUNDARY: serialBit = bsShift_reg[0];
        default: serialBit = bypass_reg;
      endcase
    end
  end

  // TDO moves on the falling edge and is driven only in shift states
  // TDO on falling edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdoOut <= 1'h0;
      tdoOe <= 1'h0;
    end
    else if (tckFall)
    begin
      tdoOut <= serialBit;
      tdoOe <= (state == SHIFT_IR) || (state == SHIFT_DR);
    end
  end

  // Pin steering per instruction; sample leaves the functional path alone
  // external test drive
  always_comb
  begin
    padOutNext = coreOut;
    padOeNext = coreOe;
    coreInNext = padIn;
    for (int i = 0; i < NUM_IO; i++)
    begin
      unique case (ir_reg)
        `BSCAN_IR_EXTEST, `BSCAN_IR_CLAMP:
        begin
          padOutNext[i] = bsUpdate_reg[3*i+1];
          padOeNext[i] = bsUpdate_reg[3*i+2];
          coreInNext[i] = bsUpdate_reg[3*i];
        end
        `BSCAN_IR_HIGHZ: padOeNext[i] = 1'h0;
        default: ;
      endcase
    end
  end

  // Registered pin outputs keep every top output on a flip-flop
  // buffer connection
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      padOut <= '0;
      padOe <= '0;
      coreIn <= '0;
      irValue <= `BSCAN_IR_BYPASS;
      tapState <= TEST_LOGIC_RESET;
    end
    else
    begin
      padOut <= padOutNext;
      padOe <= padOeNext;
      coreIn <= coreInNext;
      irValue <= ir_reg;
      tapState <= state;
    end
  end

endmodule : bscan_tap

// ### hdl/bscan_tap_regs.svh
// Constants for the boundary-scan test logic: instruction codes and widths.
// Assumes inclusion by the package and the design modules only.
`ifndef BSCAN_TAP_REGS_SVH
`define BSCAN_TAP_REGS_SVH

`define BSCAN_IR_WIDTH 3
`define BSCAN_IR_EXTEST 3'h0
`define BSCAN_IR_SAMPLE 3'h1
`define BSCAN_IR_HIGHZ 3'h5
`define BSCAN_IR_CLAMP 3'h6
`define BSCAN_IR_BYPASS 3'h7
`define BSCAN_IR_CAPTURE 3'h1
`define BSCAN_ID_WIDTH 32
`define BSCAN_CELLS_PER_IO 3
`define BSCAN_RESET_ONES 5
`define BSCAN_TCK_MAX_MHZ 20

`endif

// ### hdl/bscan_pkg.sv
// Types shared by the boundary-scan test logic.
// Assumes the constants header sits beside it.
`include "bscan_tap_regs.svh"

package bscan_pkg;

  // Sixteen controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE,
    SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
    SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
  } bscan_state_t;

  // Data register currently between the serial pins
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_BOUNDARY
  } bscan_dr_sel_t;

endpackage : bscan_pkg

// ### hdl/bscan_tap_fsm.sv
// Sixteen-state controller of the test access port.
// Assumes a one-cycle strobe on each rising test clock edge, with TMS already synchronised.
`timescale 1ns/1ps

module bscan_tap_fsm
  import bscan_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tckRise,
  input wire logic tmsSync,
  output bscan_pkg::bscan_state_t state
);
  import bscan_pkg::*;

  bscan_state_t stateNext;

  // Standard boundary-scan transitions, TMS only
  // state diagram
  always_comb
  begin
    stateNext = state;
    unique case (state)
      TEST_LOGIC_RESET: stateNext = tmsSync ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: stateNext = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_DR: stateNext = tmsSync ? SELECT_IR : CAPTURE_DR;
      CAPTURE_DR: stateNext = tmsSync ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: stateNext = tmsSync ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: stateNext = tmsSync ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: stateNext = tmsSync ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: stateNext = tmsSync ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: stateNext = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
      SELECT_IR: stateNext = tmsSync ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: stateNext = tmsSync ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: stateNext = tmsSync ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: stateNext = tmsSync ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: stateNext = tmsSync ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: stateNext = tmsSync ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: stateNext = tmsSync ? SELECT_DR : RUN_TEST_IDLE;
    endcase
  end

  // Power-on reset lands in Test-Logic-Reset; moves only on a test clock rise
  // TMS-driven steps
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= TEST_LOGIC_RESET;
    else if (tckRise)
      state <= stateNext;
  end

endmodule : bscan_tap_fsm

// ### bench/bscan_tap_properties.sv
// Checker bound to the boundary-scan top.
// Assumes clk runs far above the test clock.
`timescale 1ns/1ps

module bscan_tap_props
  import bscan_pkg::*;
#(
  parameter int NUM_IO = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsDriven,
  input wire logic tdoOut,
  input wire logic tdoOe,
  input wire logic [NUM_IO-1:0] coreOut,
  input wire logic [NUM_IO-1:0] coreOe,
  input wire logic [NUM_IO-1:0] padIn,
  input wire logic [NUM_IO-1:0] padOut,
  input wire logic [NUM_IO-1:0] padOe,
  input wire logic [NUM_IO-1:0] coreIn,
  input wire logic [2:0] irValue,
  input wire bscan_pkg::bscan_state_t tapState
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic tckSeen;
  logic [2:0] onesCount;

  // Test clock rises with TMS read high; saturates so it never wraps
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      {tckSeen, onesCount} <= 4'h0;
    else
    begin
      tckSeen <= tck;
      if (tck && !tckSeen)
        onesCount <= (tms || !tmsDriven) ? onesCount + {2'h0, onesCount != 3'h7} : 3'h0;
    end

  AST_TDO_OE: assert property (tdoOe |->
    tapState inside {SHIFT_IR, SHIFT_DR, EXIT1_IR, EXIT1_DR}) else $error("tdo enable");
  AST_STEP_ON_RISE: assert property ($changed(tapState) |-> $past(tck, 3))
    else $error("state step");
  AST_TDO_ON_FALL: assert property ($changed(tdoOut) |-> !$past(tck, 2))
    else $error("tdo edge");
  AST_TMS_RESET: assert property (onesCount >= 3'h5 |->
    ##[0:10] tapState == TEST_LOGIC_RESET) else $error("tms reset");
  AST_RESET_IR: assert property ((tapState == TEST_LOGIC_RESET) [*3] |->
    irValue == 3'h7) else $error("reset ir");
  AST_HIGHZ: assert property ((irValue == 3'h5) [*2] |-> padOe == '0)
    else $error("high z");
  AST_PASS: assert property ((irValue inside {3'h1, 3'h7}) [*2] |->
    padOut == $past(coreOut) && padOe == $past(coreOe) && coreIn == $past(padIn))
    else $error("pass");
  AST_CLAMP: assert property ((irValue == 3'h6) [*3] |->
    $stable(padOut) && $stable(padOe)) else $error("clamp");
endmodule : bscan_tap_props

bind bscan_tap bscan_tap_props #(.NUM_IO(NUM_IO)) u_props (.clk, .reset_n, .tck, .tms,
  .tmsDriven, .tdoOut, .tdoOe, .coreOut, .coreOe, .padIn, .padOut, .padOe, .coreIn,
  .irValue, .tapState);

// ### bench/bscan_tester.sv
// Board-side test controller model.
// Assumes the bench calls step; TDO resolved here.
`timescale 1ns/1ps

module bscan_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdoOut,
  input wire logic tdoOe
);
  logic tdoPin;

  // Released TDO shows the inverse, never a lucky match
  assign tdoPin = tdoOe ? tdoOut : ~tdoOut;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    q = tdoPin;
    #62.5 tck = 1'b0;
  endtask : step
endmodule : bscan_tester

// ### bench/tb.sv
// Self-checking bench for the boundary-scan top.
// Assumes the tester model owns the test port.
`timescale 1ns/1ps

module tb;
  import bscan_pkg::*;
  localparam logic [2:0] CODES [5] = '{3'h1, 3'h7, 3'h5, 3'h0, 3'h6};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic tmsDriven = 1'b1;
  logic tck, tms, tdi, tdoOut, tdoOe;
  logic [3:0] coreOut = '0, coreOe = '0, padIn = '0, padOut, padOe, coreIn;
  logic [2:0] irValue;
  bscan_state_t tapState;
  logic [31:0] seed = 32'hcb64, v = '0, p = '0, q, e = '0, x = '0;
  int errors = 0;
  int samplesChecked = 0;

  always #5 clk = ~clk;

  bscan_tap i_bscan_tap (.clk, .reset_n, .tck, .tms, .tmsDriven, .tdi, .tdoOut, .tdoOe,
    .coreOut, .coreOe, .padIn, .padOut, .padOe, .coreIn, .irValue, .tapState);
  bscan_tester tester (.tck, .tms, .tdi, .tdoOut, .tdoOe);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Queue model of a len-bit register: captured bits leave first, then the TDI bits
  function automatic logic [31:0] model_out(input int len, input int n, input logic [31:0] cap,
                                            input logic [31:0] din);
    bit chainQ[$];
    model_out = '0;
    for (int i = 0; i < len; i++)
      chainQ.push_back(cap[i]);
    for (int i = 0; i < n; i++)
    begin
      model_out[i] = chainQ.pop_front();
      chainQ.push_back(din[i]);
    end
  endfunction : model_out

  task automatic tx(input logic m);
    logic d;
    tester.step(m, 1'b0, d);
  endtask : tx

  // One scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic b;
    dout = '0;
    tx(1'b1);
    if (ir)
      tx(1'b1);
    tx(1'b0);
    tx(1'b0);
    for (int i = 0; i < n; i++)
    begin
      tester.step(i == n - 1, din[i], b);
      dout[i] = b;
      if (i < n - 1)
        chk("oe", 1, tdoOe);
    end
    tx(1'b1);
    tx(1'b0);
    chk("oe", 0, tdoOe);
  endtask : scan

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // Far above the expected run of about 17 us
  initial
  begin
    #100000;
    errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial
  begin
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk("por", {TEST_LOGIC_RESET, 3'h7, 1'b0}, {tapState, irValue, tdoOe});
    tx(1'b0);
    for (int k = 0; k < 5; k++)
    begin
      scan(1'b1, 3, {29'h0, CODES[k]}, q);
      repeat (2) @(negedge clk);
      chk("ircap", 1, q);
      chk("ir model", model_out(3, 3, 32'h1, {29'h0, CODES[k]}), q);
      chk("ir", CODES[k], irValue);
      v = rnd();
      {coreOut, coreOe, padIn} = v[11:0];
      repeat (2) @(negedge clk);
      // Capture image and the pins driven from the update latch
      for (int i = 0; i < 4; i++)
      begin
        e[3*i +: 3] = {coreOe[i], coreOut[i], padIn[i]};
        x[4+i] = p[3*i+5];
        x[i] = p[3*i+6];
      end
      if (CODES[k] == 3'h5)
        chk("hiz", 0, padOe);
      if (CODES[k] == 3'h1 || CODES[k] == 3'h7)
        chk("pass", {coreOut, coreOe, padIn}, {padOut, padOe, coreIn});
      if (CODES[k] == 3'h0 || CODES[k] == 3'h6)
        chk("drive", x, {padOut, padOe});
      if (CODES[k] == 3'h1)
      begin
        p = rnd();
        scan(1'b0, 16, p, q);
        chk("chain", {p[3:0], e[11:0]}, q[15:0]);
        chk("chain model", model_out(12, 16, e, p), q);
      end
      if (CODES[k] == 3'h0)
      begin
        scan(1'b0, 12, p >> 4, q);
        chk("extest", e & 32'h249, q & 32'h249);
        chk("extest model", model_out(12, 12, e, p >> 4) & 32'h249, q & 32'h249);
      end
      if (CODES[k] == 3'h7 || CODES[k] == 3'h6)
      begin
        v = rnd();
        scan(1'b0, 8, v, q);
        chk("bypass", {v[6:0], 1'b0}, q[7:0]);
        chk("bypass model", model_out(1, 8, 32'h0, v), q);
      end
      $display("test code %h done", CODES[k]);
    end
    tx(1'b1);
    tx(1'b0);
    tx(1'b0);
    repeat (5) tx(1'b1);
    repeat (3) @(negedge clk);
    chk("tms reset", {TEST_LOGIC_RESET, 3'h7}, {tapState, irValue});
    tx(1'b0);
    @(negedge clk) tmsDriven = 1'b0;
    repeat (5) tx(1'b0);
    repeat (3) @(negedge clk);
    chk("pull-up", TEST_LOGIC_RESET, tapState);
    tmsDriven = 1'b1;
    tx(1'b0);
    scan(1'b1, 3, 32'h5, q);
    @(negedge clk) reset_n = 1'b0;
    @(negedge clk) reset_n = 1'b1;
    @(negedge clk);
    chk("rerun", {TEST_LOGIC_RESET, 3'h7, 1'b0}, {tapState, irValue, tdoOe});
    $display("test resets done");
    finish_test();
  end
endmodule : tb
